// ---- core/iep_defines.vh ----
// Constants for the interrupt enable and priority block
// How it works
// - Enable register bits 0..5 enable ext0, timer0, ext1, timer1, serial, timer2.
// - Enable bit 7 gates all sources; 0 blocks every request.
// - Bit 6 of both registers always reads as 1.
// - Priority register bits 0..5 hold per-source priority in same order.
// - Priority bit 1 places the source in the high group.
// - Halt bit 0: priority bits are used, high group served first.
// - Halt bit 1: priority ignored, every enabled source is served in the low group.
`ifndef IEP_DEFINES_VH
`define IEP_DEFINES_VH
`define IEP_OFS_ENABLE      8'hA8
`define IEP_OFS_PRIO        8'hB8
`define IEP_OFS_SERVICE     8'hC0
`define IEP_BIT_GATE        7
`define IEP_BIT_HALT        7
`define IEP_BIT_RSVD        6
`define IEP_NSRC            6
`define IEP_ENABLE_RST      8'h40
`define IEP_PRIO_RST        8'h40
`define IEP_RESP_OKAY       2'b00
`define IEP_RESP_SLVERR     2'b10
`endif

// ---- core/iep_pick.v ----
// Lowest-index-first picker over six request lines
`timescale 1ns/1ps
module iep_pick (
   input  wire [5:0] i_req,
   output reg        o_any,
   output reg  [2:0] o_idx
);
   integer k;
   always @* begin
      o_any = 1'b0;
      o_idx = 3'd0;
      for (k = 5; k >= 0; k = k - 1) begin
         if (i_req[k]) begin
            o_any = 1'b1;
            o_idx = k[2:0];
         end
      end
   end
endmodule

// ---- core/iep_top.v ----
// Interrupt enable, priority selection and AXI4-Lite register slave
`timescale 1ns/1ps
`include "iep_defines.vh"
module iep_top (
   input  wire        I_CLK,
   input  wire        I_RESET_N,
   input  wire [5:0]  I_REQ,
   input  wire        I_ACK,
   input  wire        I_RETI,
   input  wire [7:0]  S_AXI_AWADDR,
   input  wire        S_AXI_AWVALID,
   output reg         S_AXI_AWREADY,
   input  wire [31:0] S_AXI_WDATA,
   input  wire [3:0]  S_AXI_WSTRB,
   input  wire        S_AXI_WVALID,
   output reg         S_AXI_WREADY,
   output reg  [1:0]  S_AXI_BRESP,
   output reg         S_AXI_BVALID,
   input  wire        S_AXI_BREADY,
   input  wire [7:0]  S_AXI_ARADDR,
   input  wire        S_AXI_ARVALID,
   output reg         S_AXI_ARREADY,
   output reg  [31:0] S_AXI_RDATA,
   output reg  [1:0]  S_AXI_RRESP,
   output reg         S_AXI_RVALID,
   input  wire        S_AXI_RREADY,
   output reg         O_IRQ,
   output reg  [2:0]  O_IRQ_ID,
   output reg         O_IRQ_HIGH
);
   ////////////////////////////////////////////////////////////////////
   reg  [7:0] enable_r;
   reg  [7:0] prio_r;
   reg        svc_low_r;
   reg        svc_high_r;
   reg        aw_held_r;
   reg  [7:0] aw_addr_r;
   reg        w_held_r;
   reg [31:0] w_data_r;
   reg        w_strb_r;

   wire       global_gate         = enable_r[`IEP_BIT_GATE];
   wire       priority_logic_halt = prio_r[`IEP_BIT_HALT];
   wire [5:0] pass_req;
   wire [5:0] high_req;
   wire [5:0] low_req;
   wire       hi_any;
   wire       lo_any;
   wire [2:0] hi_idx;
   wire [2:0] lo_idx;

   // Gate off everything when the global bit is clear
   assign pass_req = global_gate ? (I_REQ & enable_r[5:0]) : 6'h00;
   // With the halt bit set every source falls into the ordinary group
   assign high_req = priority_logic_halt ? 6'h00 : (pass_req & prio_r[5:0]);
   assign low_req  = pass_req & ~high_req;

   iep_pick u_pick_hi (
      .i_req (high_req),
      .o_any (hi_any),
      .o_idx (hi_idx)
   );
   iep_pick u_pick_lo (
      .i_req (low_req),
      .o_any (lo_any),
      .o_idx (lo_idx)
   );

   ////////////////////////////////////////////////////////////////////
   // Request selection with two-level nesting
   reg        irq_nxt;
   reg  [2:0] id_nxt;
   reg        high_nxt;
   always @* begin
      irq_nxt  = 1'b0;
      id_nxt   = 3'd0;
      high_nxt = 1'b0;
      if (hi_any && !svc_high_r) begin
         irq_nxt  = 1'b1;
         id_nxt   = hi_idx;
         high_nxt = 1'b1;
      end else if (lo_any && !svc_high_r && !svc_low_r) begin
         irq_nxt = 1'b1;
         id_nxt  = lo_idx;
      end
   end

   // Service level tracking: ack enters the level, return leaves the top one
   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         O_IRQ      <= 1'b0;
         O_IRQ_ID   <= 3'd0;
         O_IRQ_HIGH <= 1'b0;
         svc_low_r  <= 1'b0;
         svc_high_r <= 1'b0;
      end else begin
         O_IRQ      <= irq_nxt;
         O_IRQ_ID   <= id_nxt;
         O_IRQ_HIGH <= high_nxt;
         if (I_ACK && O_IRQ) begin
            if (O_IRQ_HIGH)
               svc_high_r <= 1'b1;
            else
               svc_low_r <= 1'b1;
         end else if (I_RETI) begin
            if (svc_high_r)
               svc_high_r <= 1'b0;
            else
               svc_low_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path; address and data accepted in either order
   wire       aw_fire  = S_AXI_AWVALID && S_AXI_AWREADY;
   wire       w_fire   = S_AXI_WVALID && S_AXI_WREADY;
   wire       have_aw  = aw_held_r || aw_fire;
   wire       have_w   = w_held_r || w_fire;
   wire [7:0] wr_addr  = aw_held_r ? aw_addr_r : S_AXI_AWADDR;
   wire [7:0] wr_byte  = w_held_r ? w_data_r[7:0] : S_AXI_WDATA[7:0];
   wire       wr_lane  = w_held_r ? w_strb_r : S_AXI_WSTRB[0];
   wire       wr_go    = have_aw && have_w && !S_AXI_BVALID;

   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         S_AXI_AWREADY <= 1'b0;
         S_AXI_WREADY  <= 1'b0;
         S_AXI_BVALID  <= 1'b0;
         S_AXI_BRESP   <= `IEP_RESP_OKAY;
         aw_held_r     <= 1'b0;
         aw_addr_r     <= 8'h00;
         w_held_r      <= 1'b0;
         w_data_r      <= 32'h0000_0000;
         w_strb_r      <= 1'b0;
         enable_r      <= `IEP_ENABLE_RST;
         prio_r        <= `IEP_PRIO_RST;
      end else begin
         S_AXI_AWREADY <= !have_aw && !S_AXI_AWREADY && !S_AXI_BVALID;
         S_AXI_WREADY  <= !have_w && !S_AXI_WREADY && !S_AXI_BVALID;
         if (aw_fire && !wr_go) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= S_AXI_AWADDR;
         end
         if (w_fire && !wr_go) begin
            w_held_r <= 1'b1;
            w_data_r <= S_AXI_WDATA;
            w_strb_r <= S_AXI_WSTRB[0];
         end
         if (wr_go) begin
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY  <= 1'b0;
            S_AXI_BVALID  <= 1'b1;
            S_AXI_BRESP   <= `IEP_RESP_OKAY;
            case (wr_addr)
               `IEP_OFS_ENABLE: if (wr_lane)
                  enable_r <= wr_byte | 8'h40;
               `IEP_OFS_PRIO: if (wr_lane)
                  prio_r <= wr_byte | 8'h40;
               `IEP_OFS_SERVICE: ;
               default: S_AXI_BRESP <= `IEP_RESP_SLVERR;
            endcase
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path; one cycle from address to data
   reg [31:0] rd_nxt;
   reg  [1:0] rresp_nxt;
   always @* begin
      rd_nxt    = 32'h0000_0000;
      rresp_nxt = `IEP_RESP_OKAY;
      case (S_AXI_ARADDR)
         `IEP_OFS_ENABLE:  rd_nxt = {24'h00_0000, enable_r | 8'h40};
         `IEP_OFS_PRIO:    rd_nxt = {24'h00_0000, prio_r | 8'h40};
         `IEP_OFS_SERVICE: rd_nxt = {28'h000_0000, pass_req != 6'h00,
                                     1'b0, svc_high_r, svc_low_r};
         default:          rresp_nxt = `IEP_RESP_SLVERR;
      endcase
   end

   always @(posedge I_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         S_AXI_ARREADY <= 1'b0;
         S_AXI_RVALID  <= 1'b0;
         S_AXI_RDATA   <= 32'h0000_0000;
         S_AXI_RRESP   <= `IEP_RESP_OKAY;
      end else begin
         S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
         if (S_AXI_ARVALID && S_AXI_ARREADY) begin
            S_AXI_RVALID <= 1'b1;
            S_AXI_RDATA  <= rd_nxt;
            S_AXI_RRESP  <= rresp_nxt;
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end
endmodule

// ---- test/iep_cpu_model.sv ----
// CPU core stand-in: takes offered interrupts and returns from them
`timescale 1ns/1ps
module iep_cpu_model (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic irq,
   input  wire logic go,
   output logic      ack,
   output logic      reti
);
   int  depth;
   int  t;
   wire take = go && irq && !ack;
   // Returns only on a quiet cycle, because an accept in the same cycle wins
   always @(posedge clk or negedge rst_n)
      if (!rst_n) begin
         ack <= 1'b0;
         reti <= 1'b0;
         depth = 0;
         t = 0;
      end else begin
         ack <= take;
         reti <= !take && !reti && depth > 0 && t < 1;
         if (ack && irq) depth++;
         if (reti) depth--;
         t = (ack || reti) ? 6 : t - 1;
      end
endmodule

// ---- test/iep_top_checker.sv ----
// Port checker for the interrupt enable and priority block
`timescale 1ns/1ps
module iep_top_checker (
   input wire logic        I_CLK,
   input wire logic        I_RESET_N,
   input wire logic [5:0]  I_REQ,
   input wire logic        I_ACK,
   input wire logic        I_RETI,
   input wire logic [7:0]  S_AXI_AWADDR,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic        O_IRQ,
   input wire logic [2:0]  O_IRQ_ID,
   input wire logic        O_IRQ_HIGH
);
   logic [7:0] en_r, pr_r, en_q, pr_q;
   logic [5:0] req_q;
   logic       hi_r, lo_r;
   wire        wr_go = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
   always_ff @(posedge I_CLK or negedge I_RESET_N)
      if (!I_RESET_N) begin
         en_r <= 8'h40;
         pr_r <= 8'h40;
         hi_r <= 1'b0;
         lo_r <= 1'b0;
      end else begin
         if (wr_go && S_AXI_AWADDR == 8'hA8) en_r <= S_AXI_WDATA[7:0];
         if (wr_go && S_AXI_AWADDR == 8'hB8) pr_r <= S_AXI_WDATA[7:0];
         if (I_ACK && O_IRQ) begin
            hi_r <= hi_r | O_IRQ_HIGH;
            lo_r <= lo_r | !O_IRQ_HIGH;
         end else if (I_RETI) begin
            hi_r <= 1'b0;
            lo_r <= lo_r & hi_r;
         end
      end
   // Delayed copies line up with the one-cycle offer latency
   always_ff @(posedge I_CLK) begin
      en_q <= en_r;
      pr_q <= pr_r;
      req_q <= I_REQ;
   end
   ////////////////////////////////////////
   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_RESET_N);
   sequence high_taken;
      I_ACK && O_IRQ && O_IRQ_HIGH;
   endsequence
   gate_block_a: assert property (O_IRQ |-> en_q[7])
      else $error("offer with gate off");
   src_enable_a: assert property (O_IRQ |-> en_q[O_IRQ_ID] && req_q[O_IRQ_ID])
      else $error("offer from disabled or idle source");
   high_group_a: assert property (O_IRQ && O_IRQ_HIGH |-> pr_q[O_IRQ_ID])
      else $error("high offer from low source");
   halt_low_a: assert property (O_IRQ && pr_q[7] |-> !O_IRQ_HIGH)
      else $error("high offer while halted");
   high_pref_a: assert property (O_IRQ && !O_IRQ_HIGH && !pr_q[7] |->
      (req_q & en_q[5:0] & pr_q[5:0]) == 6'h00) else $error("low chosen over high");
   high_busy_a: assert property (hi_r && $past(hi_r) |-> !O_IRQ)
      else $error("offer during high service");
   low_nest_a: assert property (lo_r && $past(lo_r) && O_IRQ |-> O_IRQ_HIGH)
      else $error("low offer during low service");
   // Offer registered at the accept edge still shows one cycle
   high_drop_a: assert property (high_taken |-> ##2 !O_IRQ)
      else $error("offer held after high accept");
endmodule
bind iep_top iep_top_checker iep_top_checker_i (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
   .I_REQ(I_REQ), .I_ACK(I_ACK), .I_RETI(I_RETI), .S_AXI_AWADDR(S_AXI_AWADDR),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
   .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .O_IRQ(O_IRQ),
   .O_IRQ_ID(O_IRQ_ID), .O_IRQ_HIGH(O_IRQ_HIGH));

// ---- test/iep_top_tb.sv ----
// Self-checking bench for the interrupt enable and priority block
`timescale 1ns/1ps
module iep_top_tb;
   logic        I_CLK = 1'b0;
   logic        I_RESET_N = 1'b0;
   logic [5:0]  I_REQ = 6'h00;
   logic [7:0]  aw_a = 8'h00, ar_a = 8'h00;
   logic [31:0] w_d = 32'h0000_0000;
   logic        aw_v = 1'b0, w_v = 1'b0, ar_v = 1'b0, go = 1'b0;
   wire         awr, wr_r, bv, arr, rv, irq, ack, reti, hi;
   wire  [1:0]  br, rr;
   wire  [2:0]  id;
   wire  [31:0] r_d;
   int          err_total = 0, tests_run = 0, cyc = 0, seed = 32'h818D_C74B;
   iep_top iep_top_i (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_REQ(I_REQ), .I_ACK(ack),
      .I_RETI(reti), .S_AXI_AWADDR(aw_a), .S_AXI_AWVALID(aw_v), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(w_d), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_v), .S_AXI_WREADY(wr_r),
      .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1), .S_AXI_ARADDR(ar_a),
      .S_AXI_ARVALID(ar_v), .S_AXI_ARREADY(arr), .S_AXI_RDATA(r_d), .S_AXI_RRESP(rr),
      .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1), .O_IRQ(irq), .O_IRQ_ID(id), .O_IRQ_HIGH(hi));
   iep_cpu_model iep_cpu_model_i (.clk(I_CLK), .rst_n(I_RESET_N), .irq(irq), .go(go),
      .ack(ack), .reti(reti));
   always #25 I_CLK = ~I_CLK;
   always @(posedge I_CLK) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         tally_and_finish;
      end
   end
   ////////////////////////////////////////
   task chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      aw_a <= a;
      w_d <= d;
      aw_v <= 1'b1;
      w_v <= 1'b1;
      do begin
         @(posedge I_CLK);
         if (awr) aw_v <= 1'b0;
         if (wr_r) w_v <= 1'b0;
      end while (bv !== 1'b1);
      chk(br, er);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      ar_a <= a;
      ar_v <= 1'b1;
      do begin
         @(posedge I_CLK);
         if (arr) ar_v <= 1'b0;
      end while (rv !== 1'b1);
      chk(r_d, e);
      chk(rr, er);
   endtask
   // Lowest index wins inside the chosen group
   function automatic logic [4:0] exp_irq(input logic [5:0] q, input logic [7:0] e,
      input logic [7:0] p);
      logic [5:0] s, h;
      s = q & e[5:0] & {6{e[7]}};
      h = p[7] ? 6'h00 : s & p[5:0];
      exp_irq = 5'h00;
      if (h != 6'h00) s = h;
      for (int i = 5; i >= 0; i--) if (s[i]) exp_irq = {1'b1, i[2:0], h != 6'h00};
   endfunction
   task tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      logic [7:0] e, p;
      repeat (8) @(posedge I_CLK);
      I_RESET_N <= 1'b1;
      @(posedge I_CLK);
      rd(8'hA8, 8'h40, 2'b00);
      rd(8'hB8, 8'h40, 2'b00);
      rd(8'h10, 8'h00, 2'b10);
      wr(8'h14, 8'hFF, 2'b10);
      $display("test registers done");
      for (int n = 0; n < 24; n++) begin
         e = (n == 0) ? 8'h3F : $random(seed);
         p = $random(seed);
         wr(8'hA8, e, 2'b00);
         wr(8'hB8, p, 2'b00);
         rd(8'hA8, e | 8'h40, 2'b00);
         rd(8'hB8, p | 8'h40, 2'b00);
         I_REQ <= $random(seed);
         repeat (2) @(posedge I_CLK);
         chk({irq, id, hi}, exp_irq(I_REQ, e, p));
      end
      $display("test priority done");
      wr(8'hA8, 8'hBF, 2'b00);
      wr(8'hB8, 8'h15, 2'b00);
      go <= 1'b1;
      repeat (400) begin
         I_REQ <= $random(seed);
         @(posedge I_CLK);
      end
      go <= 1'b0;
      I_REQ <= 6'h00;
      repeat (30) @(posedge I_CLK);
      rd(8'hC0, 8'h00, 2'b00);
      $display("test nesting done");
      tally_and_finish;
   end
endmodule
